/* File: rtl/uhp_port_regs.sv */
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module uhp_port_regs #(
  parameter int TICK_CYCLES = uhp_pkg::UHP_TICK_CYCLES, // cycles per ms
  parameter int CUR_W = uhp_pkg::UHP_CUR_W              // current width
) (
  input wire logic ref_clk,                    // system clock
  input wire logic reset,                      // sync, active high
  input wire logic hsel,                       // slave select
  input wire logic [31:0] haddr,               // byte address
  input wire logic [1:0] htrans,               // transfer type
  input wire logic hwrite,                     // write when high
  input wire logic [2:0] hsize,                // transfer size
  input wire logic [31:0] hwdata,              // write data
  input wire logic hready,                     // bus ready
  output logic hreadyout,                      // slave ready
  output logic [31:0] hrdata,                  // read data
  output logic hresp,                          // always okay
  input wire logic [uhp_pkg::UHP_NUM_CH-1:0] chanVbusAboveMax, // comparator
  input wire logic [uhp_pkg::UHP_NUM_CH-1:0] chanVbusBelowMin, // comparator
  input wire logic [uhp_pkg::UHP_NUM_CH-1:0] chanPowerFail,    // fail level
  input wire logic [uhp_pkg::UHP_NUM_CH*CUR_W-1:0] chanCurrent, // samples
  output logic [uhp_pkg::UHP_NUM_CH-1:0] chanDataEn,   // data switch
  output logic [uhp_pkg::UHP_NUM_CH-1:0] chanVbusEn,   // vbus switch
  output logic [uhp_pkg::UHP_NUM_CH-1:0] chanBoost,    // boost enable
  output logic [uhp_pkg::UHP_NUM_CH-1:0] chanDischarge, // discharge on
  output logic irq                             // level interrupt
);
  import uhp_pkg::*;

  if (CUR_W < 1 || CUR_W > 32) begin : g_bad
    $error("uhp_port_regs: CUR_W must be 1 to 32");
  end

  //////////////////////////////////////////////////////////////////////////
  // all state of the block
  typedef struct packed {
    logic [31:0] rdata;           // read data of the data phase
    logic ready;                  // hreadyout
    logic resp;                   // hresp, never error
    logic rdPend;                 // read waiting for its data
    logic wrPend;                 // write in its data phase
    logic [7:0] addr;             // latched address
    logic [UHP_EN_W-1:0] enables; // data and vbus enables
    logic [UHP_SEL_W-1:0] sel;    // channel shown in condition
    logic [UHP_NUM_CH-1:0] boost; // boost enables
    logic [CUR_W-1:0] limit;      // overcurrent limit
    logic [31:0] faults;          // sticky fault bytes
    logic [UHP_NUM_CH-1:0] intStat; // sticky per-channel events
    logic [UHP_NUM_CH-1:0] intMask; // interrupt enables
    logic irq;
  } uhp_regs_t;

  uhp_regs_t st;
  uhp_regs_t next_st;

  logic msTick;                     // millisecond enable
  logic accept;                     // address phase taken
  logic [31:0] rd;                  // read mux result
  logic [31:0] clrMask;             // fault bits cleared this cycle
  logic [31:0] faultSet;            // fault bits raised this cycle
  logic [31:0] keepBits;            // fault bits that must survive
  logic [UHP_NUM_CH-1:0] intClr;    // status bits cleared by software
  logic [UHP_NUM_CH-1:0] chEvt;     // new fault on a channel
  logic [UHP_NUM_CH-1:0] ocEvt;     // overcurrent per channel
  logic [UHP_NUM_CH-1:0] bdEvt;     // back-drive per channel
  logic [UHP_NUM_CH-1:0] dsEvt;     // discharge failure per channel
  logic selVbus;                    // vbus enable of selected channel
  logic selErr;                     // any fault of selected channel

  //////////////////////////////////////////////////////////////////////////
  // millisecond base shared by all channels
  uhp_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .reset(reset),
    .msTick(msTick)
  );

  //////////////////////////////////////////////////////////////////////////
  // per-channel monitors and output mapping
  for (genvar c = 0; c < UHP_NUM_CH; c++) begin : g_ch
    uhp_channel #(
      .CUR_W(CUR_W)
    ) u_chan (
      .ref_clk(ref_clk),
      .reset(reset),
      .msTick(msTick),
      .vbusOn(st.enables[c*UHP_PAIR_W + UHP_VBUS_POS]),
      .vbusAboveMax(chanVbusAboveMax[c]),
      .vbusBelowMin(chanVbusBelowMin[c]),
      .current(chanCurrent[c*CUR_W +: CUR_W]),
      .limit(st.limit),
      .overcurrentEvt(ocEvt[c]),
      .backdriveEvt(bdEvt[c]),
      .dischargeEvt(dsEvt[c]),
      .dischargeOn(chanDischarge[c])
    );
    // fault byte, lsb first: oc, back-drive, power, discharge
    assign faultSet[c*UHP_BYTE_W +: UHP_BYTE_W] = {{UHP_RSV_W{1'b0}},
      dsEvt[c], chanPowerFail[c], bdEvt[c], ocEvt[c]};
    // even bit data, odd bit vbus
    assign chanDataEn[c] = st.enables[c*UHP_PAIR_W + UHP_DATA_POS];
    assign chanVbusEn[c] = st.enables[c*UHP_PAIR_W + UHP_VBUS_POS];
  end

  assign selVbus = st.enables[UHP_PAIR_W*st.sel + UHP_VBUS_POS];
  assign selErr = |st.faults[UHP_BYTE_W*st.sel +: UHP_BYTE_W];
  assign keepBits = st.faults & ~clrMask;

  //////////////////////////////////////////////////////////////////////////
  // bus slave, register file and fault bookkeeping
  always_comb begin
    next_st = st;
    clrMask = '0;
    intClr = '0;
    chEvt = '0;
    accept = hsel && htrans[UHP_HTRANS_ACT] && hready &&
      (hsize == UHP_HSIZE_WORD);
    // read mux; reserved and unmapped bits read zero
    rd = '0;
    case (st.addr)
      UHP_OFF_ENABLES: rd[UHP_EN_W-1:0] = st.enables;
      UHP_OFF_SELECT: rd[UHP_SEL_W-1:0] = st.sel;
      UHP_OFF_CONDITION: begin
        rd[UHP_COND_VBUS] = selVbus;
        rd[UHP_COND_DATA] =
          st.enables[UHP_PAIR_W*st.sel + UHP_DATA_POS];
        rd[UHP_COND_ERR] = selErr;
        rd[UHP_COND_BOOST] = st.boost[st.sel];
      end
      UHP_OFF_BOOST: rd[UHP_NUM_CH-1:0] = st.boost;
      UHP_OFF_LIMIT: rd[CUR_W-1:0] = st.limit;
      UHP_OFF_FAULTS: rd = st.faults;
      UHP_OFF_INTSTAT: rd[UHP_NUM_CH-1:0] = st.intStat;
      UHP_OFF_INTMASK: rd[UHP_NUM_CH-1:0] = st.intMask;
      default: rd = '0;
    endcase
    // write data phase; fields narrower than the word drop the rest
    if (st.wrPend) begin
      next_st.wrPend = 1'b0;
      case (st.addr)
        UHP_OFF_ENABLES: begin
          // all four channels change together
          next_st.enables = hwdata[UHP_EN_W-1:0];
        end
        UHP_OFF_SELECT: next_st.sel = hwdata[UHP_SEL_W-1:0];
        UHP_OFF_BOOST: next_st.boost = hwdata[UHP_NUM_CH-1:0];
        UHP_OFF_LIMIT: next_st.limit = hwdata[CUR_W-1:0];
        UHP_OFF_CLEAR: begin
          // only the named channel's byte goes
          clrMask = UHP_BYTE_ONES <<
            (UHP_BYTE_W * hwdata[UHP_SEL_W-1:0]);
        end
        UHP_OFF_INTSTAT: intClr = hwdata[UHP_NUM_CH-1:0];
        UHP_OFF_INTMASK: next_st.intMask = hwdata[UHP_NUM_CH-1:0];
        // fault and condition words are read only, the rest unmapped
        default: next_st.wrPend = 1'b0;
      endcase
    end
    // a fault raised in the clearing cycle survives the clear
    next_st.faults = ((st.faults & ~clrMask) | faultSet) &
      UHP_FAULT_VALID;
    // event: a fault bit that was not already set
    for (int c = 0; c < UHP_NUM_CH; c++) begin
      chEvt[c] = |(faultSet[c*UHP_BYTE_W +: UHP_BYTE_W] &
        ~st.faults[c*UHP_BYTE_W +: UHP_BYTE_W]);
    end
    next_st.intStat = (st.intStat & ~intClr) | chEvt;
    next_st.irq = |(next_st.intStat & next_st.intMask);
    // read data phase: one wait state, so a write just before is seen
    if (st.rdPend) begin
      next_st.rdPend = 1'b0;
      next_st.ready = 1'b1;
      next_st.rdata = rd;
    end
    // address phase
    if (accept) begin
      next_st.addr = haddr[7:0];
      if (hwrite) begin
        next_st.wrPend = 1'b1;
      end else begin
        next_st.rdPend = 1'b1;
        next_st.ready = 1'b0;
      end
    end
  end

  // one register for the whole state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
      st.ready <= 1'b1;
      st.enables <= UHP_ENABLES_RST;
      st.limit <= UHP_LIMIT_RST[CUR_W-1:0];
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.ready;
  assign hrdata = st.rdata;
  assign hresp = st.resp;
  assign chanBoost = st.boost;
  assign irq = st.irq;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_enWrite;
    st.wrPend && st.addr == UHP_OFF_ENABLES |=>
      chanDataEn[0] == $past(hwdata[0]) &&
      chanVbusEn[0] == $past(hwdata[1]) &&
      chanDataEn[3] == $past(hwdata[6]) &&
      chanVbusEn[3] == $past(hwdata[7]);
  endproperty
  a_enWrite: assert property (p_enWrite)
    else $error("enables write did not reach channel switches");

  sequence s_readEn;
    accept && !hwrite && haddr[7:0] == UHP_OFF_ENABLES ##1 !hreadyout;
  endsequence
  property p_enRead;
    s_readEn |=> hreadyout && hrdata[31:UHP_EN_W] == '0 &&
      hrdata[UHP_EN_W-1:0] == $past(st.enables);
  endproperty
  a_enRead: assert property (p_enRead)
    else $error("enables read back wrong or reserved bits set");

  property p_cond;
    st.rdPend && st.addr == UHP_OFF_CONDITION |=>
      hrdata[UHP_COND_VBUS] == $past(selVbus) &&
      hrdata[UHP_COND_ERR] == $past(selErr) &&
      hrdata[31:UHP_COND_BOOST+1] == '0;
  endproperty
  a_cond: assert property (p_cond)
    else $error("condition word does not match selected channel");

  property p_faultMap;
    ocEvt[1] ##0 bdEvt[2] |=>
      st.faults[UHP_BYTE_W + UHP_FLT_OC] &&
      st.faults[2*UHP_BYTE_W + UHP_FLT_BD] &&
      (st.faults & ~UHP_FAULT_VALID) == '0;
  endproperty
  a_faultMap: assert property (p_faultMap)
    else $error("fault landed in the wrong byte or bit");

  property p_clearOne;
    st.wrPend && st.addr == UHP_OFF_CLEAR |=>
      (st.faults & $past(keepBits)) == $past(keepBits);
  endproperty
  a_clearOne: assert property (p_clearOne)
    else $error("clear touched another channel's faults");

  property p_sticky;
    !(st.wrPend && st.addr == UHP_OFF_CLEAR) |=>
      (st.faults & $past(st.faults)) == $past(st.faults);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("fault flag dropped without a clear");

endmodule

/* File: rtl/uhp_pkg.sv */
package uhp_pkg;

  // number of software-controlled downstream channels
  localparam int UHP_NUM_CH = 4;
  localparam int UHP_SEL_W = 2;              // channel index width
  localparam int UHP_BYTE_W = 8;             // one fault byte per channel
  localparam int UHP_RSV_W = 4;              // reserved top of a fault byte

  //////////////////////////////////////////////////////////////////////////
  // register byte offsets, one aligned word each
  localparam logic [7:0] UHP_OFF_ENABLES = 8'h00;   // channel enables
  localparam logic [7:0] UHP_OFF_SELECT = 8'h04;    // condition selector
  localparam logic [7:0] UHP_OFF_CONDITION = 8'h08; // port condition
  localparam logic [7:0] UHP_OFF_BOOST = 8'h0c;     // boost enables
  localparam logic [7:0] UHP_OFF_LIMIT = 8'h10;     // current limit
  localparam logic [7:0] UHP_OFF_FAULTS = 8'h14;    // hub fault flags
  localparam logic [7:0] UHP_OFF_CLEAR = 8'h18;     // clear one channel
  localparam logic [7:0] UHP_OFF_INTSTAT = 8'h1c;   // interrupt status
  localparam logic [7:0] UHP_OFF_INTMASK = 8'h20;   // interrupt mask

  //////////////////////////////////////////////////////////////////////////
  // field layouts
  localparam int UHP_EN_W = 8;         // used part of the enables word
  localparam int UHP_PAIR_W = 2;       // bits per channel in enables
  localparam int UHP_DATA_POS = 0;     // high-speed data enable in pair
  localparam int UHP_VBUS_POS = 1;     // vbus enable in pair
  localparam int UHP_COND_VBUS = 0;    // condition: vbus enabled
  localparam int UHP_COND_DATA = 1;    // condition: data enabled
  localparam int UHP_COND_ERR = 3;     // condition: any fault flag
  localparam int UHP_COND_BOOST = 4;   // condition: boost enabled
  localparam int UHP_FLT_OC = 0;       // overcurrent in fault byte
  localparam int UHP_FLT_BD = 1;       // vbus back-drive
  localparam int UHP_FLT_PWR = 2;      // power system failure
  localparam int UHP_FLT_DIS = 3;      // discharge failure
  localparam logic [31:0] UHP_BYTE_ONES = 32'h0000_00ff;
  localparam logic [31:0] UHP_FAULT_VALID = 32'h0f0f_0f0f;

  // reset values
  localparam logic [7:0] UHP_ENABLES_RST = 8'h00;
  localparam logic [31:0] UHP_LIMIT_RST = 32'h0000_0800;

  // bus encodings
  localparam int UHP_HTRANS_ACT = 1;             // nonseq/seq bit of htrans
  localparam logic [2:0] UHP_HSIZE_WORD = 3'h2;
  localparam int UHP_CUR_W = 16;                 // current sample width

  //////////////////////////////////////////////////////////////////////////
  // timing: times in their own unit, counts derived from the clock
  localparam int UHP_CLK_PERIOD_NS = 8;
  localparam int UHP_MS_NS = 1000000;
  localparam int UHP_TICK_CYCLES = UHP_MS_NS / UHP_CLK_PERIOD_NS;
  localparam int UHP_BACKDRIVE_MS = 5;
  localparam int UHP_DISCHARGE_MS = 200;
  // one more tick than the limit makes the wait strictly longer
  localparam int UHP_BACKDRIVE_TICKS = UHP_BACKDRIVE_MS + 1;
  localparam int UHP_DISCHARGE_TICKS = UHP_DISCHARGE_MS;
  localparam int UHP_TCNT_W = 8;                 // ms tick counter width

  // discharge check sequence, gray coded
  typedef enum logic [1:0] {
    UHP_DS_IDLE = 2'b00,
    UHP_DS_WAIT = 2'b01,
    UHP_DS_CHECK = 2'b11
  } uhp_ds_state_t;

endpackage

/* File: rtl/uhp_tick.sv */
`timescale 1ns/1ns
module uhp_tick #(
  parameter int TICK_CYCLES = uhp_pkg::UHP_TICK_CYCLES  // cycles per tick
) (
  input wire logic ref_clk,  // system clock
  input wire logic reset,    // synchronous, active high
  output logic msTick        // one-cycle pulse once a millisecond
);
  import uhp_pkg::*;

  localparam int CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2) begin : g_bad
    $error("uhp_tick: TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;  // cycles into the current tick
    logic tick;          // registered pulse
  } uhp_tick_st_t;

  uhp_tick_st_t st;
  uhp_tick_st_t next_st;

  // free-running divider, wraps at the last cycle
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign msTick = st.tick;

endmodule

/* File: rtl/uhp_channel.sv */
`timescale 1ns/1ns
module uhp_channel #(
  parameter int CUR_W = uhp_pkg::UHP_CUR_W  // current sample width
) (
  input wire logic ref_clk,             // system clock
  input wire logic reset,               // synchronous, active high
  input wire logic msTick,              // millisecond enable
  input wire logic vbusOn,              // vbus enable of this channel
  input wire logic vbusAboveMax,        // vbus above back-drive level
  input wire logic vbusBelowMin,        // vbus below discharged level
  input wire logic [CUR_W-1:0] current, // measured current
  input wire logic [CUR_W-1:0] limit,   // software current limit
  output logic overcurrentEvt,          // current above limit
  output logic backdriveEvt,            // back-drive held too long
  output logic dischargeEvt,            // vbus failed to discharge
  output logic dischargeOn              // discharge circuit active
);
  import uhp_pkg::*;

  typedef struct packed {
    uhp_ds_state_t ds;            // discharge sequence state
    logic [UHP_TCNT_W-1:0] bdCnt; // ticks with vbus high
    logic [UHP_TCNT_W-1:0] dsCnt; // ticks into the discharge wait
    logic prevOn;                 // vbus enable one cycle ago
    logic oc;
    logic bd;
    logic dsErr;
    logic dsOn;
  } uhp_chan_st_t;

  uhp_chan_st_t st;
  uhp_chan_st_t next_st;

  // fault detection and discharge sequencing
  always_comb begin
    next_st = st;
    next_st.prevOn = vbusOn;
    next_st.dsErr = 1'b0;
    next_st.oc = current > limit;
    // any dip below the level restarts the continuous-time count
    if (!vbusAboveMax) begin
      next_st.bdCnt = '0;
    end else if (msTick && st.bdCnt != UHP_TCNT_W'(UHP_BACKDRIVE_TICKS)) begin
      next_st.bdCnt = st.bdCnt + 1'b1;
    end
    next_st.bd = vbusAboveMax &&
      (st.bdCnt == UHP_TCNT_W'(UHP_BACKDRIVE_TICKS));
    case (st.ds)
      UHP_DS_IDLE: begin
        // vbus switched off: start discharging
        if (st.prevOn && !vbusOn) begin
          next_st.ds = UHP_DS_WAIT;
          next_st.dsCnt = '0;
          next_st.dsOn = 1'b1;
        end
      end
      UHP_DS_WAIT: begin
        // re-enabling vbus aborts the check, nothing to judge
        if (vbusOn) begin
          next_st.ds = UHP_DS_IDLE;
          next_st.dsOn = 1'b0;
        end else if (st.dsCnt == UHP_TCNT_W'(UHP_DISCHARGE_TICKS)) begin
          next_st.ds = UHP_DS_CHECK;
        end else if (msTick) begin
          next_st.dsCnt = st.dsCnt + 1'b1;
        end
      end
      UHP_DS_CHECK: begin
        next_st.dsErr = !vbusBelowMin;
        next_st.dsOn = 1'b0;
        next_st.ds = UHP_DS_IDLE;
      end
      default: begin
        next_st.ds = UHP_DS_IDLE;
        next_st.dsOn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign overcurrentEvt = st.oc;
  assign backdriveEvt = st.bd;
  assign dischargeEvt = st.dsErr;
  assign dischargeOn = st.dsOn;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_oc;
    @(posedge ref_clk) disable iff (reset)
    overcurrentEvt |-> $past(current) > $past(limit);
  endproperty
  a_oc: assert property (p_oc)
    else $error("overcurrent flagged without current above limit");

  property p_bd;
    @(posedge ref_clk) disable iff (reset)
    !vbusAboveMax |=> !backdriveEvt [*2];
  endproperty
  a_bd: assert property (p_bd)
    else $error("back-drive flagged after vbus dropped");

  sequence s_dsStart;
    $fell(vbusOn) && st.ds == UHP_DS_IDLE;
  endsequence
  property p_ds;
    @(posedge ref_clk) disable iff (reset)
    s_dsStart |=> dischargeOn ##1 (dischargeOn || vbusOn);
  endproperty
  a_ds: assert property (p_ds)
    else $error("discharge not started when vbus switched off");

  property p_dsErr;
    @(posedge ref_clk) disable iff (reset)
    dischargeEvt |-> !$past(vbusBelowMin) && !dischargeOn;
  endproperty
  a_dsErr: assert property (p_dsErr)
    else $error("discharge error with vbus below level");

endmodule

/* File: verification/uhp_partner_model.sv */
`timescale 1ns/1ns
// far side: four downstream ports with rails and loads
module uhp_partner_model (
  input wire logic [uhp_pkg::UHP_NUM_CH-1:0] vbusEn,    // rail switch state
  input wire logic [uhp_pkg::UHP_NUM_CH-1:0] overdrive, // device backfeeds
  input wire logic [uhp_pkg::UHP_NUM_CH-1:0] stuck,     // rail won't drain
  input wire logic [uhp_pkg::UHP_NUM_CH-1:0] pwrFail,   // supply trouble
  input wire logic [63:0] load,                         // demanded current
  output logic [uhp_pkg::UHP_NUM_CH-1:0] aboveMax,      // over 5.150 V
  output logic [uhp_pkg::UHP_NUM_CH-1:0] belowMin,      // under 0.750 V
  output logic [uhp_pkg::UHP_NUM_CH-1:0] powerFail,     // fail level
  output logic [63:0] current                           // measured current
);
  import uhp_pkg::*;
  //////////////////////////////////////////////////////////////////////
  // comparators follow the rail at once; no slow drain modelled
  assign aboveMax = overdrive;
  assign belowMin = ~vbusEn & ~stuck;
  assign powerFail = pwrFail;
  // a port only draws current while its rail is on
  always_comb begin
    for (int c = 0; c < UHP_NUM_CH; c++) begin
      current[c*16 +: 16] = vbusEn[c] ? load[c*16 +: 16] : 16'h0;
    end
  end
endmodule

/* File: verification/test_usb_hub_port_status_control.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_usb_hub_port_status_control;
  import uhp_pkg::*;
  localparam int TICK = 16; // short millisecond keeps the run brief
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2; // word transfers only
  logic [31:0] hrdata;
  logic hready, hreadyout, hresp, irq;
  logic [3:0] overdrive = 4'h0, stuck = 4'h0, pwrFail = 4'h0;
  logic [63:0] load = 64'h0, current;
  logic [3:0] above, below, pfail, dataEn, vbusEn, boost, disch;
  int miscompares = 0;
  int nChecks = 0;
  int cyc = 0;
  assign hready = hreadyout; // single slave owns the bus
  always #4 ref_clk = ~ref_clk;
  uhp_port_regs #(.TICK_CYCLES(TICK)) u_dut (.ref_clk(ref_clk),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .chanVbusAboveMax(above), .chanVbusBelowMin(below),
    .chanPowerFail(pfail), .chanCurrent(current), .chanDataEn(dataEn),
    .chanVbusEn(vbusEn), .chanBoost(boost), .chanDischarge(disch),
    .irq(irq));
  uhp_partner_model u_far (.vbusEn(vbusEn), .overdrive(overdrive),
    .stuck(stuck), .pwrFail(pwrFail), .load(load), .aboveMax(above),
    .belowMin(below), .powerFail(pfail), .current(current));
  //////////////////////////////////////////////////////////////////////
  // one single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK("hrdata", e, r)
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic tReset();
    rd(UHP_OFF_ENABLES, 32'h0);
    rd(UHP_OFF_FAULTS, 32'h0);
    rd(UHP_OFF_LIMIT, 32'h0000_0800);
    rd(8'h24, 32'h0);
    $display("test reset done");
  endtask
  task automatic tEnables();
    wr(UHP_OFF_ENABLES, 32'hffff_ffa5);
    rd(UHP_OFF_ENABLES, 32'h0000_00a5);
    @(posedge ref_clk);
    `CHK("dataEn", 4'h3, dataEn)
    `CHK("vbusEn", 4'hc, vbusEn)
    `CHK("hresp", 1'b0, hresp)
    $display("test enables done");
  endtask
  task automatic tCondition();
    wr(UHP_OFF_BOOST, 32'h4);
    wr(UHP_OFF_SELECT, 32'h2);
    `CHK("boost", 4'h4, boost)
    rd(UHP_OFF_CONDITION, 32'h11);
    wr(UHP_OFF_SELECT, 32'h0);
    rd(UHP_OFF_CONDITION, 32'h02);
    $display("test condition done");
  endtask
  // ch2 sits exactly on the limit, so it must not trip
  task automatic tFaults();
    wr(UHP_OFF_INTMASK, 32'h2);
    wr(UHP_OFF_LIMIT, 32'h100);
    load <= {16'h0200, 16'h0100, 32'h0};
    pwrFail <= 4'h2;
    repeat (4) @(posedge ref_clk);
    pwrFail <= 4'h0;
    rd(UHP_OFF_FAULTS, 32'h0100_0400);
    `CHK("irq", 1'b1, irq)
    wr(UHP_OFF_FAULTS, 32'h0);
    wr(UHP_OFF_CLEAR, 32'h1);
    rd(UHP_OFF_FAULTS, 32'h0100_0000);
    rd(UHP_OFF_INTSTAT, 32'h0000_000a);
    wr(UHP_OFF_INTSTAT, 32'h2);
    @(posedge ref_clk);
    `CHK("irq", 1'b0, irq)
    wr(UHP_OFF_SELECT, 32'h3);
    rd(UHP_OFF_CONDITION, 32'h09);
    overdrive <= 4'h1;
    repeat (4*TICK) @(posedge ref_clk);
    overdrive <= 4'h0;
    rd(UHP_OFF_FAULTS, 32'h0100_0000);
    overdrive <= 4'h1;
    repeat (7*TICK) @(posedge ref_clk);
    overdrive <= 4'h0;
    rd(UHP_OFF_FAULTS, 32'h0100_0002);
    $display("test faults done");
  endtask
  // ch2 rail never drains, ch3 drains at once
  task automatic tDischarge();
    stuck <= 4'h4;
    wr(UHP_OFF_ENABLES, 32'h0000_0005);
    repeat (2) @(posedge ref_clk);
    `CHK("disch", 4'hc, disch)
    repeat (190*TICK) @(posedge ref_clk);
    `CHK("disch", 4'hc, disch)
    repeat (12*TICK) @(posedge ref_clk);
    `CHK("disch", 4'h0, disch)
    rd(UHP_OFF_FAULTS, 32'h0108_0002);
    $display("test discharge done");
  endtask
  //////////////////////////////////////////////////////////////////////
  // a hang ends the run through the same report
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    tReset();
    tEnables();
    tCondition();
    tFaults();
    tDischarge();
    summarize();
  end
endmodule
